// ===== shared/afi_consts.svh
// Purpose: Offsets, fields, reset values and timing counts of the fault interrupt latch
// Assumes: 100 MHz mclk_i
// Notes: Included by its bare name
`ifndef AFI_CONSTS_SVH
`define AFI_CONSTS_SVH

`define AFI_ADDR_W 8
`define AFI_DATA_W 16
`define AFI_OFF_SRC_CTRL 8'h05
`define AFI_OFF_STATUS 8'h06
`define AFI_OFF_IO_CTRL 8'h0a

`define AFI_IO_POL_BIT 15
`define AFI_IO_OUTEN_BIT 11
`define AFI_IO_KEEP_MASK 16'hf800
`define AFI_DIS_LSB 8
`define AFI_DIS_MSB 14
`define AFI_MASK_MSB 7
`define AFI_SRC_CTRL_KEEP 16'h7fff
`define AFI_PWR_BIT 0
`define AFI_OVP_BIT 1
`define AFI_NSRC 8

`define AFI_RST_SRC_CTRL 16'h0000
`define AFI_RST_STATUS 8'h00
`define AFI_RST_IO_CTRL 16'h0000
`define AFI_RST_IRQ_PIN 1'b1

`define AFI_CLK_PERIOD_NS 10
`define AFI_STREAM_IDLE_NS 20000
`define AFI_STREAM_IDLE_CYC (`AFI_STREAM_IDLE_NS / `AFI_CLK_PERIOD_NS)

`endif

// ===== shared/afi_pkg.sv
// Purpose: Types shared by the fault interrupt latch files
// Assumes: Constants come from afi_consts.svh
// Notes: Register request travels as one packed struct
`include "afi_consts.svh"
package afi_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`AFI_ADDR_W-1:0] addr;
		logic [`AFI_DATA_W-1:0] wdata;
	} afi_reg_req_t;

	typedef enum logic {
		AFI_STRM_LOST,
		AFI_STRM_LIVE
	} afi_strm_state_t;
endpackage

// ===== hw/afi_sync2.sv
// Purpose: Two flip-flop synchroniser, one per bit
// Assumes: Inputs asynchronous to mclk_i
// Notes: First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module afi_sync2 #(
	parameter int W = 8
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	import afi_pkg::*;

	logic [W-1:0] meta_reg;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge mclk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					meta_reg[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end else begin
					meta_reg[g] <= async_i[g];
					sync_o[g] <= meta_reg[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== hw/afi_stream_watch.sv
// Purpose: Power-up enable from activity on the playback serial input
// Assumes: stream_i already synchronised
// Notes: Idle longer than the timeout drops the enable
`timescale 1ns/1ns
`default_nettype none
`include "afi_consts.svh"
module afi_stream_watch #(
	parameter int IDLE_CYC = `AFI_STREAM_IDLE_CYC
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic stream_i,
	output logic powerup_en_o
);
	import afi_pkg::*;

	logic stream_q;
	logic edge_seen;
	logic [15:0] idle_reg;
	afi_strm_state_t state_reg;

	assign edge_seen = stream_i ^ stream_q;
	assign powerup_en_o = (state_reg == AFI_STRM_LIVE);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stream_q <= 1'b0;
		end else begin
			stream_q <= stream_i;
		end
	end

	// Lost after IDLE_CYC quiet cycles, live again on any edge
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= AFI_STRM_LOST;
			idle_reg <= 16'h0000;
		end else begin
			case (state_reg)
				AFI_STRM_LOST: begin
					idle_reg <= 16'h0000;
					if (edge_seen) begin
						state_reg <= AFI_STRM_LIVE;
					end
				end
				AFI_STRM_LIVE: begin
					if (edge_seen) begin
						idle_reg <= 16'h0000;
					end else if (idle_reg >= 16'(IDLE_CYC - 1)) begin
						state_reg <= AFI_STRM_LOST;
						idle_reg <= 16'h0000;
					end else begin
						idle_reg <= idle_reg + 16'h0001;
					end
				end
				default: begin
					state_reg <= AFI_STRM_LOST;
					idle_reg <= 16'h0000;
				end
			endcase
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	stream_edge_live_a: assert property (edge_seen |=> powerup_en_o)
		else $error("stream edge did not raise power-up enable");
	stream_cover_lost_c: cover property ($fell(powerup_en_o));
endmodule
`default_nettype wire

// ===== hw/afi_fault_irq.sv
// Purpose: Fault and power event latch with polarity-selectable IRQ pin
// Assumes: Register port is the decoded control bus; pins are asynchronous
// Notes: Status reads in the low 8 bits; upper bits read zero
//
// Behaviour
// - Pin active when enabled status bit set
// - IO control top bit selects active-high
// - Writing one clears that status bit
// - Disable bits block recording and pin
// - Mask bits keep status, block pin
// - Pin held until unmasked bits cleared
// - Output turn-on sets power event bit
// - Over-voltage detect sets status bit one
// - Clearing power event leaves others pending
// - Stream loss drops power-up enable, return retriggers
// - Over-voltage after turn-on latches, needs clear
// - IO control accepts polarity plus output enable
// - Source control accepts enable and mask example
`timescale 1ns/1ns
`default_nettype none
`include "afi_consts.svh"
module afi_fault_irq #(
	parameter int IDLE_CYC = `AFI_STREAM_IDLE_CYC
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire afi_pkg::afi_reg_req_t reg_req_i,
	output logic [`AFI_DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic block_enable_control_i,
	input wire logic over_voltage_detect_i,
	input wire logic [`AFI_NSRC-3:0] aux_fault_i,
	input wire logic playback_serial_in_i,
	output logic output_powerup_enable_o,
	output logic class_d_enable_o,
	output logic irq_pin_o
);
	import afi_pkg::*;

	localparam int NSRC = `AFI_NSRC;
	localparam logic [NSRC-1:0] RST_STATUS = `AFI_RST_STATUS;

	logic [`AFI_DATA_W-1:0] src_ctrl_reg;
	logic [`AFI_DATA_W-1:0] io_ctrl_reg;
	logic [NSRC-1:0] status_reg;
	logic [NSRC-1:0] status_next;
	logic [NSRC-1:0] ev_q;
	logic [NSRC-1:0] ev_s;
	logic [NSRC-1:0] rise_vec;
	logic [NSRC-1:0] en_vec;
	logic [NSRC-1:0] mask_vec;
	logic [NSRC-1:0] set_vec;
	logic [NSRC-1:0] clr_vec;
	logic [NSRC:0] sync_out;
	logic stream_s;
	logic drive_on;
	logic drive_on_reg;
	logic irq_act;
	logic irq_pin_reg;
	logic pol_high;
	logic wr_src;
	logic wr_status;
	logic wr_io;
	logic [`AFI_DATA_W-1:0] rdata_reg;
	logic rvalid_reg;

	// Fault and stream pins cross into mclk_i before logic reads them; block_enable_control_i is used unsynchronised
	afi_sync2 #(
		.W(NSRC + 1)
	) u_sync (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.async_i({playback_serial_in_i, aux_fault_i, over_voltage_detect_i, 1'b0}),
		.sync_o(sync_out)
	);

	assign stream_s = sync_out[NSRC];
	assign ev_s = {sync_out[NSRC-1:1], 1'b0};

	afi_stream_watch #(
		.IDLE_CYC(IDLE_CYC)
	) u_watch (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.stream_i(stream_s),
		.powerup_en_o(output_powerup_enable_o)
	);

	// Register port decode
	assign wr_src = reg_req_i.wr && (reg_req_i.addr == `AFI_OFF_SRC_CTRL);
	assign wr_status = reg_req_i.wr && (reg_req_i.addr == `AFI_OFF_STATUS);
	assign wr_io = reg_req_i.wr && (reg_req_i.addr == `AFI_OFF_IO_CTRL);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src_ctrl_reg <= `AFI_RST_SRC_CTRL;
		end else if (wr_src) begin
			src_ctrl_reg <= reg_req_i.wdata & `AFI_SRC_CTRL_KEEP;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			io_ctrl_reg <= `AFI_RST_IO_CTRL;
		end else if (wr_io) begin
			io_ctrl_reg <= reg_req_i.wdata & `AFI_IO_KEEP_MASK;
		end
	end

	assign pol_high = io_ctrl_reg[`AFI_IO_POL_BIT];

	// Output stage on while enabled and the stream is present
	assign drive_on = (io_ctrl_reg[`AFI_IO_OUTEN_BIT] || block_enable_control_i)
		&& output_powerup_enable_o;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			drive_on_reg <= 1'b0;
			ev_q <= '0;
		end else begin
			drive_on_reg <= drive_on;
			ev_q <= ev_s;
		end
	end

	assign class_d_enable_o = drive_on_reg;

	// Power event on each turn-on, including stream return
	assign rise_vec[`AFI_PWR_BIT] = drive_on && !drive_on_reg;
	// Over-voltage may fire just after turn-on; latched like any other
	assign rise_vec[NSRC-1:1] = ev_s[NSRC-1:1] & ~ev_q[NSRC-1:1];

	// Top source has no disable bit and is always recorded
	assign en_vec = {1'b1, ~src_ctrl_reg[`AFI_DIS_MSB:`AFI_DIS_LSB]};
	assign mask_vec = src_ctrl_reg[`AFI_MASK_MSB:0];
	assign set_vec = rise_vec & en_vec;

	// Every written one clears; the host is expected to write one bit only
	assign clr_vec = wr_status ? reg_req_i.wdata[NSRC-1:0] : '0;
	// One latch cell per source; set wins so no event is lost to a clear
	genvar s;
	generate
		for (s = 0; s < NSRC; s++) begin : g_src
			assign status_next[s] = (status_reg[s] && !clr_vec[s]) || set_vec[s];
			always_ff @(posedge mclk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					status_reg[s] <= RST_STATUS[s];
				end else begin
					status_reg[s] <= status_next[s];
				end
			end
		end
	endgenerate

	// Masked bits stay visible in status but never reach the pin
	assign irq_act = |(status_reg & ~mask_vec & en_vec);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_pin_reg <= `AFI_RST_IRQ_PIN;
		end else begin
			irq_pin_reg <= pol_high ? irq_act : !irq_act;
		end
	end

	assign irq_pin_o = irq_pin_reg;

	// Read data registered one cycle after the strobe
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				case (reg_req_i.addr)
					`AFI_OFF_SRC_CTRL: begin
						rdata_reg <= src_ctrl_reg;
					end
					`AFI_OFF_STATUS: begin
						rdata_reg <= {{(`AFI_DATA_W-NSRC){1'b0}}, status_reg};
					end
					`AFI_OFF_IO_CTRL: begin
						rdata_reg <= io_ctrl_reg;
					end
					default: begin
						rdata_reg <= '0;
					end
				endcase
			end
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	pin_active_level_a: assert property (irq_act |=> irq_pin_o == $past(pol_high))
		else $error("pin not active while enabled status is set");

	pin_idle_level_a: assert property (status_reg == '0 |=> irq_pin_o == !$past(pol_high))
		else $error("pin active with status empty");

	pin_polarity_a: assert property ((!irq_act && pol_high) ##1 (!irq_act && pol_high)
		|-> irq_pin_o == 1'b0)
		else $error("active-high pin not low when idle");

	w1c_clear_a: assert property (wr_status && ((reg_req_i.wdata[NSRC-1:0] & set_vec) == '0)
		|=> (status_reg & $past(reg_req_i.wdata[NSRC-1:0])) == '0)
		else $error("written one did not clear status bit");

	set_wins_a: assert property (set_vec != '0
		|=> (status_reg & $past(set_vec)) == $past(set_vec))
		else $error("event lost against clear");

	disabled_block_a: assert property ((status_reg & ~$past(status_reg) & ~$past(en_vec)) == '0)
		else $error("disabled source recorded");

	power_event_a: assert property ($rose(drive_on_reg) && $past(en_vec[0]) |-> status_reg[0])
		else $error("turn-on did not set power event");

	ovp_event_a: assert property (rise_vec[`AFI_OVP_BIT] && en_vec[`AFI_OVP_BIT]
		|=> status_reg[`AFI_OVP_BIT])
		else $error("over-voltage not latched");

	masked_quiet_a: assert property (((status_reg & ~mask_vec & en_vec) == '0) && status_reg != '0
		|=> irq_pin_o == !$past(pol_high))
		else $error("masked source drove pin");

	status_read_a: assert property (reg_req_i.rd && reg_req_i.addr == `AFI_OFF_STATUS
		|=> reg_rvalid_o && reg_rdata_o[NSRC-1:0] == $past(status_reg))
		else $error("status read mismatch");

	rvalid_idle_a: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
		else $error("read valid without a read strobe");

	rdata_hold_a: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
		else $error("read data changed without a read");

	status_upper_a: assert property (reg_req_i.rd && reg_req_i.addr == `AFI_OFF_STATUS
		|=> reg_rdata_o[`AFI_DATA_W-1:NSRC] == '0)
		else $error("status upper bits not zero");

	src_read_a: assert property (reg_req_i.rd && reg_req_i.addr == `AFI_OFF_SRC_CTRL
		|=> reg_rdata_o == $past(src_ctrl_reg))
		else $error("source control read mismatch");

	io_read_a: assert property (reg_req_i.rd && reg_req_i.addr == `AFI_OFF_IO_CTRL
		|=> reg_rdata_o == $past(io_ctrl_reg))
		else $error("io control read mismatch");

	unmapped_read_a: assert property (reg_req_i.rd && reg_req_i.addr != `AFI_OFF_SRC_CTRL
		&& reg_req_i.addr != `AFI_OFF_STATUS && reg_req_i.addr != `AFI_OFF_IO_CTRL
		|=> reg_rdata_o == '0)
		else $error("unmapped read not zero");

	src_write_a: assert property (wr_src
		|=> src_ctrl_reg == ($past(reg_req_i.wdata) & `AFI_SRC_CTRL_KEEP))
		else $error("source control write lost");

	io_write_a: assert property (wr_io
		|=> io_ctrl_reg == ($past(reg_req_i.wdata) & `AFI_IO_KEEP_MASK))
		else $error("io control write lost");

	pol_bit_a: assert property (wr_io
		|=> pol_high == $past(reg_req_i.wdata[`AFI_IO_POL_BIT]))
		else $error("polarity bit not taken");

	class_d_follow_a: assert property (1'b1 |=> class_d_enable_o == $past(drive_on))
		else $error("output stage does not follow enable");

	status_hold_a: assert property (set_vec == '0 && clr_vec == '0
		|=> $stable(status_reg))
		else $error("status changed with no event or clear");

	masked_records_a: assert property ((rise_vec & en_vec & mask_vec) != '0
		|=> (status_reg & $past(rise_vec & en_vec & mask_vec)) == $past(rise_vec & en_vec & mask_vec))
		else $error("masked source not recorded");

	no_spurious_set_a: assert property ((status_reg & ~$past(status_reg) & ~$past(set_vec)) == '0)
		else $error("status bit set without event");

	ovp_needs_clear_a: assert property (status_reg[`AFI_OVP_BIT] && !clr_vec[`AFI_OVP_BIT]
		|=> status_reg[`AFI_OVP_BIT])
		else $error("over-voltage cleared without a write");

	pwr_clear_only_a: assert property (wr_status && reg_req_i.wdata[NSRC-1:0] == 8'h01
		&& status_reg[`AFI_OVP_BIT] |=> status_reg[`AFI_OVP_BIT])
		else $error("power clear dropped over-voltage");

	irq_raised_c: cover property (!irq_act ##1 irq_act);
	power_event_c: cover property (rise_vec[`AFI_PWR_BIT] && en_vec[`AFI_PWR_BIT]);
	set_and_clear_c: cover property ((set_vec & clr_vec) != '0);
	pwr_clear_ovp_left_c: cover property (wr_status && reg_req_i.wdata[NSRC-1:0] == 8'h01
		&& status_reg[`AFI_OVP_BIT]);
endmodule
`default_nettype wire

// ===== verif/afi_host_irq_model.sv
// Purpose: Host external interrupt input feeding the service routine
// Assumes: Same clock as the device; polarity told by the bench
// Notes: Request normalised to active high
`timescale 1ns/1ns
`default_nettype none
module afi_host_irq_model (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic irq_pin_i,
	input wire logic active_high_i,
	output logic irq_req_o
);
	// One input flop, so the bench sees the pin as the host would
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_req_o <= 1'b0;
		end else begin
			irq_req_o <= active_high_i ? irq_pin_i : !irq_pin_i;
		end
	end
endmodule
`default_nettype wire

// ===== verif/afi_fault_irq_bench.sv
// Purpose: Register-level regression of the fault interrupt latch
// Assumes: Stream timeout shortened to 20 cycles
// Notes: Host clears one status bit per write
`timescale 1ns/1ns
`default_nettype none
`include "afi_consts.svh"
module afi_fault_irq_bench;
	import afi_pkg::*;
	localparam int IDLE = 20;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	afi_reg_req_t req = '0;
	logic over_voltage_detect = 1'b0, blk_en = 1'b0, strm = 1'b0, strm_on = 1'b0, pol = 1'b0;
	logic [5:0] aux = '0;
	logic [15:0] rdata, v;
	logic [15:0] ctl = 16'h6070;
	logic rvalid, pwr_en, cd_en, pin, host_req, en;
	int err_total = 0;
	int cmp_count = 0;
	int src;

	afi_fault_irq #(.IDLE_CYC(IDLE)) u_afi_fault_irq (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.block_enable_control_i(blk_en), .over_voltage_detect_i(over_voltage_detect), .aux_fault_i(aux),
		.playback_serial_in_i(strm), .output_powerup_enable_o(pwr_en),
		.class_d_enable_o(cd_en), .irq_pin_o(pin));
	afi_host_irq_model u_afi_host_irq_model (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.irq_pin_i(pin), .active_high_i(pol), .irq_req_o(host_req));

	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	// Stream activity: any edge counts, so toggle every cycle
	always @(posedge mclk_i) begin
		if (strm_on) begin
			strm <= ~strm;
		end
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("Compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		req <= {1'b1, 1'b0, a, d};
		@(posedge mclk_i);
		req <= '0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		int i;
		@(posedge mclk_i);
		req <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge mclk_i);
		req <= '0;
		#1;
		for (i = 0; i < 4 && rvalid !== 1'b1; i++) begin
			@(posedge mclk_i);
			#1;
		end
		if (i == 4) begin
			err_total++;
			summarize();
		end else begin
			chk($sformatf("reg %h", a), rdata, e);
		end
	endtask
	// Bounded wait on the host's view of the pin
	task automatic wait_req(input logic e);
		int i;
		for (i = 0; i < 40 && host_req !== e; i++) begin
			@(posedge mclk_i);
			#1;
		end
		chk("host irq", {15'h0, host_req}, {15'h0, e});
	endtask

	initial begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		summarize();
	end

	initial begin
		repeat (20) @(posedge mclk_i);
		chk("pin in reset", {15'h0, pin}, 16'h0001);
		resetn_i <= 1'b1;
		rchk(`AFI_OFF_SRC_CTRL, 16'h0000);
		rchk(`AFI_OFF_STATUS, 16'h0000);
		rchk(`AFI_OFF_IO_CTRL, 16'h0000);
		rchk(8'h07, 16'h0000);
		wr(`AFI_OFF_IO_CTRL, 16'hffff);
		rchk(`AFI_OFF_IO_CTRL, 16'hf800);
		wr(`AFI_OFF_SRC_CTRL, 16'hffff);
		rchk(`AFI_OFF_SRC_CTRL, 16'h7fff);
		wr(`AFI_OFF_IO_CTRL, 16'h8800);
		rchk(`AFI_OFF_IO_CTRL, 16'h8800);
		wr(`AFI_OFF_SRC_CTRL, ctl);
		rchk(`AFI_OFF_SRC_CTRL, 16'h6070);
		// Host view must settle on the new polarity before waiting for a request
		@(posedge mclk_i);
		pol <= 1'b1;
		repeat (2) @(posedge mclk_i);
		wait_req(1'b0);
		chk("idle pin high pol", {15'h0, pin}, 16'h0000);
		@(posedge mclk_i);
		strm_on <= 1'b1;
		wait_req(1'b1);
		chk("powerup", {15'h0, pwr_en}, 16'h0001);
		chk("class d", {15'h0, cd_en}, 16'h0001);
		@(posedge mclk_i);
		over_voltage_detect <= 1'b1;
		repeat (6) @(posedge mclk_i);
		rchk(`AFI_OFF_STATUS, 16'h0003);
		wr(`AFI_OFF_STATUS, 16'h0001);
		rchk(`AFI_OFF_STATUS, 16'h0002);
		chk("pin held", {15'h0, host_req}, 16'h0001);
		wr(`AFI_OFF_STATUS, 16'h0002);
		rchk(`AFI_OFF_STATUS, 16'h0000);
		wait_req(1'b0);
		@(posedge mclk_i);
		over_voltage_detect <= 1'b0;
		for (src = 2; src < 8; src++) begin
			en = !(src < 7 && ctl[8 + src]);
			aux[src - 2] <= 1'b1;
			repeat (6) @(posedge mclk_i);
			rchk(`AFI_OFF_STATUS, en ? 16'h1 << src : 16'h0);
			chk("aux pin", {15'h0, host_req}, {15'h0, en & !ctl[src]});
			wr(`AFI_OFF_STATUS, 16'h1 << src);
			aux[src - 2] <= 1'b0;
		end
		rchk(`AFI_OFF_STATUS, 16'h0000);
		@(posedge mclk_i);
		strm_on <= 1'b0;
		repeat (IDLE + 10) @(posedge mclk_i);
		chk("powerup lost", {15'h0, pwr_en}, 16'h0000);
		chk("class d off", {15'h0, cd_en}, 16'h0000);
		// Second turn-on through the block enable, active-low pin
		wr(`AFI_OFF_IO_CTRL, 16'h0000);
		// Pin flips to its active-low idle level a cycle after the write lands
		@(posedge mclk_i);
		pol <= 1'b0;
		repeat (3) @(posedge mclk_i);
		wait_req(1'b0);
		@(posedge mclk_i);
		blk_en <= 1'b1;
		strm_on <= 1'b1;
		wait_req(1'b1);
		chk("low pol pin", {15'h0, pin}, 16'h0000);
		rchk(`AFI_OFF_STATUS, 16'h0001);
		wr(`AFI_OFF_STATUS, 16'h0001);
		wait_req(1'b0);
		chk("low pol idle", {15'h0, pin}, 16'h0001);
		summarize();
	end
endmodule
`default_nettype wire
